// *** rtl/tdr_router.sv ***
// tdr_router: host-side glue of a tape controller card.
// assumes mode, selects and requests are static or same-clock logic; host
// read strobes and the tape interrupt come from pins (3-stage sync).
// Operation
// - diagnostic mode reads return AA only
// - step enable low stops tape clock
// - host step read gives one tape clock cycle
// - base address chosen among four options
// - interrupt on channel 3, else 5
// - enable a only: channel 3, write selects
// - enable b only: channel 1, dual selects
// - tape interrupt passes to host line
// - sense or statistics transfer eight bytes
// - read of step address gives pulse while stepping (enable low)
// - single mode channel 1 from request b, dual from dual read
`default_nettype none
module tdr_router #(
    parameter int COUNT_W = 16                  // dma byte count width
) (
    input  wire logic               clk_in,     // 100 MHz
    input  wire logic               rst_in,     // sync, active high
    input  wire tdr_pkg::tdr_mode_t mode_in,    // mode/control bits
    input  wire tdr_pkg::tdr_dreq_t dreq_in,    // internal dma requests
    input  wire logic [1:0]         base_address_select_in, // jumper
    input  wire logic               interrupt_line_select_in, // 1: ch 5
    input  wire logic               tape_irq_in,    // tape interrupt pin
    input  wire logic               io_read_in,     // host read strobe pin
    input  wire logic [9:0]         io_addr_in,     // host i/o address
    input  wire logic [7:0]         rd_data_in,     // normal read data
    input  wire logic [7:0]         cmd_code_in,    // current command
    input  wire logic [COUNT_W-1:0] host_count_in,  // host byte count
    output logic [7:0]              rd_data_out,    // read data to host
    output logic                    sel_out,        // block decoded
    output tdr_pkg::tdr_host_drq_t  host_drq_out,   // host dma requests
    output logic                    irq3_out,       // host irq channel 3
    output logic                    irq5_out,       // host irq channel 5
    output logic                    tape_logic_clock_out, // gated clock
    output logic                    single_step_pulse_out, // step pulse
    output logic [COUNT_W-1:0]      xfer_count_out  // bytes to transfer
);
    // the short-count override needs at least 16 bits of count
    if (COUNT_W < 16)
    begin : g_bad_count_w
        $error("COUNT_W must be at least 16");
    end

    function automatic logic [9:0] base_of(input logic [1:0] s);
        case (s)
            2'h0:    base_of = tdr_pkg::BASE_0;
            2'h1:    base_of = tdr_pkg::BASE_1;
            2'h2:    base_of = tdr_pkg::BASE_2;
            default: base_of = tdr_pkg::BASE_3;
        endcase
    endfunction

    // pin synchronisers; only stages 2 and 3 are looked at
    logic [2:0] rd_sync_q;
    logic [2:0] irq_sync_q;
    logic       rd_lvl_q;
    logic       irq_lvl_q;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rd_sync_q  <= 3'h0;
            irq_sync_q <= 3'h0;
            rd_lvl_q   <= 1'b0;
            irq_lvl_q  <= 1'b0;
        end
        else
        begin
            rd_sync_q  <= {rd_sync_q[1:0], io_read_in};
            irq_sync_q <= {irq_sync_q[1:0], tape_irq_in};
            if (rd_sync_q[1] == rd_sync_q[2])
                rd_lvl_q <= rd_sync_q[2];
            if (irq_sync_q[1] == irq_sync_q[2])
                irq_lvl_q <= irq_sync_q[2];
        end
    end

    logic [9:0] base_w;
    logic       hit_w;
    logic       rd_rise_w;
    logic       rd_prev_q;
    assign base_w = base_of(base_address_select_in);
    assign hit_w  = io_addr_in[9:4] == base_w[9:4] &&
                    io_addr_in[3:0] < tdr_pkg::OFS_LIMIT;
    assign rd_rise_w = rd_lvl_q && !rd_prev_q;

    // read path and decode
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rd_prev_q   <= 1'b0;
            sel_out     <= 1'b0;
            rd_data_out <= 8'h00;
        end
        else
        begin
            rd_prev_q <= rd_lvl_q;
            sel_out   <= hit_w;
            if (rd_lvl_q && hit_w)
                rd_data_out <= mode_in.diag_mode ? tdr_pkg::DIAG_BYTE
                                                 : rd_data_in;
        end
    end

    // dma routing; enables pick one channel, write and dual bits pick its source
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            host_drq_out <= '0;
        else if (mode_in.route_enable_a && !mode_in.route_enable_b)
            host_drq_out <= '{drq1: 1'b0,
                drq3: mode_in.write_dir ? dreq_in.internal_dma_request_a
                    : dreq_in.internal_dma_request_b};
        else if (!mode_in.route_enable_a && mode_in.route_enable_b)
            host_drq_out <= '{drq3: 1'b0,
                drq1: mode_in.dual_mode
                    ? dreq_in.internal_dma_request_dual_read
                    : dreq_in.internal_dma_request_b};
        else
            host_drq_out <= '0;
    end

    // interrupt steering
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            irq3_out <= 1'b0;
            irq5_out <= 1'b0;
        end
        else
        begin
            irq3_out <= irq_lvl_q && !interrupt_line_select_in;
            irq5_out <= irq_lvl_q && interrupt_line_select_in;
        end
    end

    // count override; host is trusted to give 512 multiples
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            xfer_count_out <= '0;
        else if (cmd_code_in == tdr_pkg::CMD_SENSE ||
                 cmd_code_in == tdr_pkg::CMD_STATS)
            xfer_count_out <= COUNT_W'(tdr_pkg::SHORT_COUNT);
        else
            xfer_count_out <= host_count_in;
    end

    // tape clock: free-run divider, or one cycle per step read
    logic [7:0] div_q;
    logic       step_w;
    assign step_w = rd_rise_w && hit_w &&
                    io_addr_in[3:0] == tdr_pkg::OFS_STEP &&
                    !mode_in.single_step_clock_enable_n;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            single_step_pulse_out <= 1'b0;
        else
            single_step_pulse_out <= step_w;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            div_q                <= 8'h00;
            tape_logic_clock_out <= 1'b0;
        end
        else if (mode_in.single_step_clock_enable_n)
        begin
            if (div_q == 8'(tdr_pkg::HALF_CYC - 1))
            begin
                div_q                <= 8'h00;
                tape_logic_clock_out <= !tape_logic_clock_out;
            end
            else
                div_q <= div_q + 8'h01;
        end
        else
        begin
            // stepping: high one cycle then low; stop parks clock low
            div_q <= 8'h00;
            if (step_w)
                tape_logic_clock_out <= 1'b1;
            else
                tape_logic_clock_out <= 1'b0;
        end
    end

    a_diag_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_lvl_q && hit_w && mode_in.diag_mode |=> rd_data_out == 8'hAA)
        else $error("diag read not AA");
    a_route_off: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_in.route_enable_a == mode_in.route_enable_b
        |=> host_drq_out == '0)
        else $error("drq active without route");
    a_step_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        !mode_in.single_step_clock_enable_n && !step_w
        && !$past(mode_in.single_step_clock_enable_n)
        |=> !tape_logic_clock_out)
        else $error("tape clock ran while stepping");
    a_step_one: assert property (@(posedge clk_in) disable iff (rst_in)
        step_w |=> tape_logic_clock_out && single_step_pulse_out)
        else $error("step gave no clock");
    a_short_count: assert property (@(posedge clk_in) disable iff (rst_in)
        cmd_code_in == 8'hC0 || cmd_code_in == 8'hC1
        |=> xfer_count_out == 16'h0008)
        else $error("sense count not 8");
    a_irq_route: assert property (@(posedge clk_in) disable iff (rst_in)
        irq_lvl_q && !interrupt_line_select_in |=> irq3_out && !irq5_out)
        else $error("irq not on channel 3");
    a_drq3_write: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_in.route_enable_a && !mode_in.route_enable_b && mode_in.write_dir
        |=> host_drq_out.drq3 == $past(dreq_in.internal_dma_request_a))
        else $error("drq3 source wrong");
    a_drq1_dual: assert property (@(posedge clk_in) disable iff (rst_in)
        !mode_in.route_enable_a && mode_in.route_enable_b && mode_in.dual_mode
        |=> host_drq_out.drq1
            == $past(dreq_in.internal_dma_request_dual_read))
        else $error("drq1 source wrong");
    a_irq_pass: assert property (@(posedge clk_in) disable iff (rst_in)
        !irq_lvl_q |=> !irq3_out && !irq5_out)
        else $error("irq without source");

    // one step: a single high cycle on both outputs, then both low
    sequence s_step_high;
        tape_logic_clock_out && single_step_pulse_out;
    endsequence
    sequence s_step_low;
        !tape_logic_clock_out && !single_step_pulse_out;
    endsequence
    a_step_width: assert property (@(posedge clk_in) disable iff (rst_in)
        step_w ##1 !mode_in.single_step_clock_enable_n
        |-> s_step_high ##1 s_step_low)
        else $error("step clock not one cycle");
endmodule // tdr_router
`default_nettype wire

// *** shared/tdr_pkg.sv ***
// tdr_pkg: constants and carrier types for the tape dma request router.
// assumes a 100 MHz system clock; no bus, every control bit is a port.
`default_nettype none
package tdr_pkg;
    localparam logic [9:0] BASE_0       = 10'h290;
    localparam logic [9:0] BASE_1       = 10'h2A0;
    localparam logic [9:0] BASE_2       = 10'h2B0;
    localparam logic [9:0] BASE_3       = 10'h2C0;
    localparam logic [3:0] OFS_STEP     = 4'h2;
    localparam logic [3:0] OFS_LIMIT    = 4'h4;
    localparam logic [7:0] DIAG_BYTE    = 8'hAA;
    localparam logic [7:0] CMD_SENSE    = 8'hC0;
    localparam logic [7:0] CMD_STATS    = 8'hC1;
    localparam logic [15:0] SHORT_COUNT = 16'h0008;
    localparam logic [15:0] BLOCK_BYTES = 16'h0200;
    localparam int TAPE_CLK_NS          = 110;
    localparam int CLK_NS               = 10;
    // half period, rounded down, at least one cycle
    localparam int HALF_CYC = (TAPE_CLK_NS / 2) / CLK_NS < 1 ? 1 :
                              (TAPE_CLK_NS / 2) / CLK_NS;

    typedef struct packed {
        logic route_enable_a;   // dma_route_enable_a
        logic route_enable_b;   // dma_route_enable_b
        logic write_dir;        // write bit
        logic dual_mode;        // dual/single
        logic diag_mode;        // diagnostic read pattern
        logic single_step_clock_enable_n;
    } tdr_mode_t;

    typedef struct packed {
        logic internal_dma_request_a;
        logic internal_dma_request_b;
        logic internal_dma_request_dual_read;
    } tdr_dreq_t;

    typedef struct packed {
        logic drq1;
        logic drq3;
    } tdr_host_drq_t;
endpackage
`default_nettype wire

// *** tb/tdr_host.sv ***
// tdr_host: host model issuing i/o read strobes to the router.
// assumes the bench calls rd() from one process at a time.
`default_nettype none
module tdr_host (
    input  wire logic       clk_in,  // system clock
    output logic            rd_out,  // read strobe level
    output logic [9:0]      addr_out // i/o address
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rd_out = 1'b0;
        addr_out = 10'h000;
    end
    // strobe and address held whole; released address shows the inverse
    task automatic rd(input logic [9:0] a, input int n);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        repeat (n) @(negedge clk_in);
        rd_out = 1'b0;
        // address outlives the strobe by the pin synchroniser's delay
        repeat (4) @(negedge clk_in);
        addr_out = ~a;
        repeat (2) @(negedge clk_in); // low gap, strobe is edge detected
    endtask
endmodule // tdr_host
`default_nettype wire

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for the tape dma request router.
// assumes tdr_host as the host side; inputs change on falling edges.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk_in, rst_in, isel, tirq, rd, sel, i3, i5;
    logic                   tclk, sp;
    tdr_pkg::tdr_mode_t     m;
    tdr_pkg::tdr_dreq_t     d;
    tdr_pkg::tdr_host_drq_t drq;
    logic [1:0]             bsel;
    logic [9:0]             addr;
    logic [7:0]             rdi, cmd, rdo;
    logic [15:0]            cnt, xc;
    int                     bad_count = 0, n_compared = 0;
    int                     np = 0, nt = 0, p0, t0;

    tdr_router i_tdr_router (.clk_in(clk_in), .rst_in(rst_in), .mode_in(m),
        .dreq_in(d), .base_address_select_in(bsel),
        .interrupt_line_select_in(isel), .tape_irq_in(tirq),
        .io_read_in(rd), .io_addr_in(addr), .rd_data_in(rdi),
        .cmd_code_in(cmd), .host_count_in(cnt), .rd_data_out(rdo),
        .sel_out(sel), .host_drq_out(drq), .irq3_out(i3), .irq5_out(i5),
        .tape_logic_clock_out(tclk), .single_step_pulse_out(sp),
        .xfer_count_out(xc));
    tdr_host i_tdr_host (.clk_in(clk_in), .rd_out(rd), .addr_out(addr));

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        np <= np + int'(sp === 1'b1);
        nt <= nt + int'(tclk === 1'b1);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [1:0] f_drq(tdr_pkg::tdr_mode_t x,
                                         tdr_pkg::tdr_dreq_t r);
        f_drq[1] = !x.route_enable_a && x.route_enable_b && (x.dual_mode ?
            r.internal_dma_request_dual_read : r.internal_dma_request_b);
        f_drq[0] = x.route_enable_a && !x.route_enable_b && (x.write_dir ?
            r.internal_dma_request_a : r.internal_dma_request_b);
    endfunction
    function automatic logic [15:0] f_cnt(logic [7:0] c, logic [15:0] n);
        f_cnt = (c == tdr_pkg::CMD_SENSE || c == tdr_pkg::CMD_STATS) ?
            tdr_pkg::SHORT_COUNT : n;
    endfunction
    function automatic logic [9:0] f_base(int k);
        f_base = k == 0 ? tdr_pkg::BASE_0 : k == 1 ? tdr_pkg::BASE_1 :
            k == 2 ? tdr_pkg::BASE_2 : tdr_pkg::BASE_3;
    endfunction

    initial
    begin
        #200us;
        bad_count++;
        results();
    end
    initial
    begin
        {m, d, bsel, isel, tirq, rdi, cmd, cnt} = '0;
        rst_in = 1'b1;
        void'($urandom(72));
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (48)
        begin
            {m, d} = 9'($urandom);
            m.single_step_clock_enable_n = 1'b1;
            cmd = $urandom_range(0, 2) == 0 ?
                tdr_pkg::CMD_SENSE + 8'($urandom_range(0, 1)) : 8'($urandom);
            cnt = 16'($urandom_range(0, 127)) << 9;
            @(negedge clk_in);
            chk(16'(drq), 16'(f_drq(m, d)));
            chk(xc, f_cnt(cmd, cnt));
        end
        for (int k = 0; k < 4; k++)
        begin
            {isel, tirq} = 2'(k);
            repeat (8) @(negedge clk_in);
            chk(16'({i5, i3}), 16'({isel & tirq, !isel & tirq}));
        end
        for (int k = 0; k < 4; k++)
        begin
            bsel = 2'(k);
            m.diag_mode = k[0];
            rdi = 8'($urandom);
            fork
                i_tdr_host.rd(f_base(k) + 10'h001, 8);
                begin
                    repeat (8) @(negedge clk_in);
                    chk(16'(sel), 16'h0001);
                end
            join
            chk(16'(sel), 16'h0000);
            chk(16'(rdo), 16'(k[0] ? tdr_pkg::DIAG_BYTE : rdi));
        end
        bsel = 2'h0;
        m.single_step_clock_enable_n = 1'b0;
        repeat (10) @(negedge clk_in);
        p0 = np;
        t0 = nt;
        repeat (20) @(negedge clk_in);
        chk(16'(nt - t0), 16'h0000);
        i_tdr_host.rd(tdr_pkg::BASE_0 + 10'(tdr_pkg::OFS_STEP), 4);
        repeat (6) @(negedge clk_in);
        chk(16'(np - p0), 16'h0001);
        chk(16'(nt - t0), 16'h0001);
        m.single_step_clock_enable_n = 1'b1;
        p0 = np;
        i_tdr_host.rd(tdr_pkg::BASE_0 + 10'(tdr_pkg::OFS_STEP), 4);
        repeat (6) @(negedge clk_in);
        chk(16'(np - p0), 16'h0000);
        t0 = nt;
        repeat (40) @(negedge clk_in);
        chk(16'(nt - t0), 16'h0014);
        results();
    end
endmodule // tb_top
`default_nettype wire
